// [rtl/brd_decoder.sv]
// Boot remap address decoder for the instruction and data bus masters.
`include "brd_regs.svh"
`default_nettype none

module brd_decoder (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Boot select strap pin
    input wire logic bootSelectPin,
    // Remap bit writes, index 0 instruction master, index 1 data master
    input wire logic [1:0] remapWrEn,
    input wire logic [1:0] remapWrVal,
    // Master requests
    input wire brd_pkg::brd_req_t [1:0] req,
    // Registered decode results, one cycle after the request
    output brd_pkg::brd_dec_t [1:0] dec,
    // Mapping state
    output logic remapBitInstrMaster,
    output logic remapBitDataMaster,
    output brd_pkg::brd_boot_cfg_t bootCfg
);
    import brd_pkg::*;

    typedef struct packed {
        logic syncFirst;
        logic syncSecond;
        logic romBoot;
        logic [1:0] remap;
        logic firstPend;
        brd_dec_t [1:0] dec;
    } brd_state_t;

    brd_state_t stateQ;
    brd_state_t stateD;
    brd_dec_t [1:0] decRaw;

    ////////////////////////////////////////////////////////////////////////////////

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_master
            brd_area_decode u_dec (
                .addr(req[gi].addr),
                .remap(stateQ.remap[gi]),
                .romBoot(stateQ.romBoot),
                .dec(decRaw[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        stateD = stateQ;
        // The synchroniser runs through reset so the strap is settled by release.
        stateD.syncFirst = bootSelectPin;
        stateD.syncSecond = stateQ.syncFirst;
        if (rst) begin
            stateD.romBoot = stateQ.syncSecond;
            stateD.remap = 2'h0;
            stateD.firstPend = 1'b1;
            stateD.dec = '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (remapWrEn[i]) begin
                    stateD.remap[i] = remapWrVal[i];
                end
                // Decoding uses the mapping in force before this cycle's remap write.
                stateD.dec[i] = decRaw[i];
                stateD.dec[i].valid = req[i].valid;
            end
            // Only the instruction master fetches the reset vector, so only it ends the wait.
            if (req[0].valid) begin
                stateD.firstPend = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        stateQ <= stateD;
    end

    assign dec = stateQ.dec;
    assign remapBitInstrMaster = stateQ.remap[0];
    assign remapBitDataMaster = stateQ.remap[1];

    // External boot runs on the slow clock with the memory controller defaults.
    always_comb begin
        bootCfg.romBoot = stateQ.romBoot;
        bootCfg.slowClock = !stateQ.romBoot;
        bootCfg.cs0ByteSelect = !stateQ.romBoot;
        bootCfg.cs0Bus16 = !stateQ.romBoot;
    end

    ////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic [1:0] inBoot;
    logic [1:0] inUnused;
    logic [3:0] areaZero;
    brd_slave_t bootSlave0;
    // The slave that the instruction master must see at zero under the present mapping.
    always_comb begin
        bootSlave0 = remapBitInstrMaster ? SLV_SRAM : (bootCfg.romBoot ? SLV_ROM : SLV_EBI);
        for (int i = 0; i < 2; i++) begin
            inBoot[i] = req[i].valid && req[i].addr <= `BRD_BOOT_TOP;
            inUnused[i] = req[i].valid && req[i].addr[31:28] > `BRD_AREA_EBI_LAST
                && req[i].addr[31:28] < `BRD_AREA_PERIPH;
        end
        areaZero = req[0].addr[31:28];
    end

    first_fetch_a: assert property (stateQ.firstPend && inBoot[0] |=> dec[0].valid
        && !dec[0].abort && dec[0].slave == $past(bootSlave0))
        else $error("first fetch not served by boot slave");

    valid_follow_a: assert property (req[1].valid |=> dec[1].valid)
        else $error("request not answered in the next cycle");

    boot_rom_a: assert property (inBoot[0] && !remapBitInstrMaster && bootCfg.romBoot
        |=> dec[0].slave == SLV_ROM && dec[0].offset == $past({8'h00, req[0].addr[19:0]}))
        else $error("ROM boot not decoded");

    boot_ebi_a: assert property (inBoot[1] && !remapBitDataMaster && !bootCfg.romBoot
        |=> dec[1].slave == SLV_EBI && dec[1].chipSel == 3'h0)
        else $error("external boot not on chip select 0");

    boot_hold_a: assert property (!$fell(rst) |-> $stable(bootCfg.romBoot))
        else $error("boot selection changed outside reset");

    remap_sram_a: assert property (inBoot[1] && remapBitDataMaster
        |=> dec[1].slave == SLV_SRAM && !dec[1].abort)
        else $error("remapped master does not see SRAM at zero");

    remap_instr_a: assert property (inBoot[0] && remapBitInstrMaster
        |=> dec[0].slave == SLV_SRAM && !dec[0].abort)
        else $error("remapped instruction master misses SRAM");

    // A write lands one cycle later and never touches the other master's bit.
    remap_write_a: assert property (remapWrEn[0]
        |=> remapBitInstrMaster == $past(remapWrVal[0]))
        else $error("instruction remap write lost");

    remap_indep_a: assert property (!remapWrEn[1] |=> $stable(remapBitDataMaster))
        else $error("data remap bit changed without a write");

    boot_only_a: assert property (inBoot[0] |=> !dec[0].abort
        && dec[0].slave inside {SLV_ROM, SLV_EBI, SLV_SRAM})
        else $error("boot region decoded to another slave");

    rom_fixed_a: assert property (req[0].valid
        && req[0].addr[31:15] == 17'(`BRD_ROM_BASE >> 15) |=> dec[0].slave == SLV_ROM)
        else $error("fixed ROM window lost");

    rom_size_a: assert property (req[0].valid
        && req[0].addr == (`BRD_ROM_BASE + `BRD_ROM_SIZE) |=> dec[0].abort)
        else $error("ROM wider than 32 KB");

    usb_map_a: assert property (req[1].valid
        && req[1].addr[31:20] == 12'(`BRD_USB_BASE >> 20) |=> dec[1].slave == SLV_USB)
        else $error("USB host window misdecoded");

    lcd_map_a: assert property (req[0].valid
        && req[0].addr[31:20] == 12'(`BRD_LCD_BASE >> 20) |=> dec[0].slave == SLV_LCD)
        else $error("display window misdecoded");

    sysper_slot_a: assert property (req[0].valid && req[0].addr >= `BRD_SYSPER_BASE
        |=> dec[0].sysPer && dec[0].slave == SLV_APB && dec[0].perSlot == $past(req[0].addr[12:8]))
        else $error("system peripheral slot wrong");

    sram_size_a: assert property (req[0].valid
        && req[0].addr == (`BRD_SRAM_BASE + `BRD_SRAM_SIZE) |=> dec[0].abort)
        else $error("SRAM wider than 16 KB");

    ext_cfg_a: assert property (!bootCfg.romBoot |-> bootCfg.slowClock
        && bootCfg.cs0ByteSelect && bootCfg.cs0Bus16)
        else $error("external boot defaults wrong");

    ebi_area_a: assert property (req[0].valid && areaZero >= 4'h1 && areaZero <= 4'h8
        |=> dec[0].slave == SLV_EBI && dec[0].chipSel == $past(3'(areaZero - 4'h1)))
        else $error("external area chip select wrong");

    unused_abort_a: assert property (inUnused[1] |=> dec[1].abort && dec[1].valid)
        else $error("unused area not aborted");

    remap_reset_a: assert property ($fell(rst) |-> !remapBitInstrMaster
        && !remapBitDataMaster)
        else $error("remap bits not cleared by reset");

    rom_boot_c: cover property (inBoot[0] && bootCfg.romBoot ##1 dec[0].slave == SLV_ROM);
    ext_boot_c: cover property (inBoot[0] && !bootCfg.romBoot ##1 dec[0].slave == SLV_EBI);
    remap_c: cover property (remapBitInstrMaster && inBoot[0] ##1 dec[0].slave == SLV_SRAM);
    first_fetch_c: cover property (stateQ.firstPend && inBoot[0]);
    abort_c: cover property (inUnused[0] ##1 dec[0].abort);

endmodule : brd_decoder

`default_nettype wire

// [rtl/brd_regs.svh]
// Address map and boot constants of the boot remap address decoder.
`ifndef BRD_REGS_SVH
`define BRD_REGS_SVH

// First decoding level: sixteen areas of 256 MB, selected by address bits 31:28.
`define BRD_AREA_INTERNAL 4'h0
`define BRD_AREA_EBI_FIRST 4'h1
`define BRD_AREA_EBI_LAST 4'h8
`define BRD_AREA_PERIPH 4'hF

// Internal memory area: second level decodes 1 MB slots, bits 27:20.
`define BRD_BOOT_BASE 32'h0000_0000
`define BRD_BOOT_TOP 32'h000F_FFFF
`define BRD_SRAM_BASE 32'h0030_0000
`define BRD_SRAM_SIZE 32'h0000_4000
`define BRD_ROM_BASE 32'h0040_0000
`define BRD_ROM_SIZE 32'h0000_8000
`define BRD_USB_BASE 32'h0050_0000
`define BRD_LCD_BASE 32'h0060_0000

// Peripheral area: user peripherals and the system peripheral window.
`define BRD_USERPER_BASE 32'hFFFA_0000
`define BRD_USERPER_TOP 32'hFFFC_FFFF
`define BRD_SYSPER_BASE 32'hFFFF_EA00
`define BRD_SYSPER_SLOT_LSB 8

// Boot pin capture: reset must cover the two synchroniser stages plus the capture.
`define BRD_RESET_MIN_CYCLES 3

`endif

// [rtl/brd_pkg.sv]
// Types shared by the boot remap address decoder.
`default_nettype none

package brd_pkg;

    typedef enum logic [2:0] {
        SLV_NONE,
        SLV_SRAM,
        SLV_ROM,
        SLV_USB,
        SLV_LCD,
        SLV_EBI,
        SLV_APB
    } brd_slave_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } brd_req_t;

    typedef struct packed {
        logic valid;
        brd_slave_t slave;
        logic [2:0] chipSel;
        logic abort;
        logic sysPer;
        logic [4:0] perSlot;
        logic [27:0] offset;
    } brd_dec_t;

    typedef struct packed {
        logic romBoot;
        logic slowClock;
        logic cs0ByteSelect;
        logic cs0Bus16;
    } brd_boot_cfg_t;

endpackage : brd_pkg

`default_nettype wire

// [rtl/brd_area_decode.sv]
// Combinational address decode of one bus master.
`include "brd_regs.svh"
`default_nettype none

module brd_area_decode (
    // Request address and mapping state
    input wire logic [31:0] addr,
    input wire logic remap,
    input wire logic romBoot,
    // Decode result, valid bit left clear
    output brd_pkg::brd_dec_t dec
);
    import brd_pkg::*;

    localparam logic [31:0] SramBase = `BRD_SRAM_BASE;
    localparam logic [31:0] RomBase = `BRD_ROM_BASE;
    localparam logic [31:0] UsbBase = `BRD_USB_BASE;
    localparam logic [31:0] LcdBase = `BRD_LCD_BASE;
    localparam logic [31:0] BootBase = `BRD_BOOT_BASE;

    logic [3:0] area;
    logic [7:0] slotMb;

    assign area = addr[31:28];
    assign slotMb = addr[27:20];

    always_comb begin
        dec = '0;
        dec.slave = SLV_NONE;
        dec.offset = addr[27:0];
        if (area == `BRD_AREA_INTERNAL) begin
            dec.offset = {8'h00, addr[19:0]};
            if (slotMb == BootBase[27:20]) begin
                // The whole first megabyte goes to the boot slave only.
                if (remap) begin
                    dec.slave = SLV_SRAM;
                end else if (romBoot) begin
                    dec.slave = SLV_ROM;
                end else begin
                    dec.slave = SLV_EBI;
                    dec.chipSel = 3'h0;
                end
            end else if (slotMb == SramBase[27:20] && addr[19:0] < `BRD_SRAM_SIZE) begin
                dec.slave = SLV_SRAM;
            end else if (slotMb == RomBase[27:20] && addr[19:0] < `BRD_ROM_SIZE) begin
                dec.slave = SLV_ROM;
            end else if (slotMb == UsbBase[27:20]) begin
                dec.slave = SLV_USB;
            end else if (slotMb == LcdBase[27:20]) begin
                dec.slave = SLV_LCD;
            end else begin
                dec.abort = 1'b1;
            end
        end else if (area >= `BRD_AREA_EBI_FIRST && area <= `BRD_AREA_EBI_LAST) begin
            dec.slave = SLV_EBI;
            dec.chipSel = 3'(area - `BRD_AREA_EBI_FIRST);
        end else if (area == `BRD_AREA_PERIPH) begin
            dec.slave = SLV_APB;
            if (addr >= `BRD_SYSPER_BASE) begin
                // Slots count in 256 bytes; a 512-byte peripheral owns two.
                dec.sysPer = 1'b1;
                dec.perSlot = addr[`BRD_SYSPER_SLOT_LSB +: 5];
            end
        end else begin
            dec.abort = 1'b1;
        end
    end

endmodule : brd_area_decode

`default_nettype wire

// [verification/brd_master_model.sv]
// Behavioural model of the instruction and data bus masters.
`default_nettype none

module brd_master_model (
    // Clock
    input wire logic core_clk,
    // Requests towards the decoder
    output brd_pkg::brd_req_t [1:0] req
);
    timeunit 1ns;
    timeprecision 100ps;
    import brd_pkg::*;

    brd_req_t [1:0] drv = '0;

    assign req = drv;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Puts one address on master m, launched just after the next rising edge.
    task automatic issue(input int m, input logic [31:0] a);
        @(posedge core_clk);
        #1;
        drv[m].valid = 1'b1;
        drv[m].addr = a;
    endtask : issue

    // A released address bus shows the inverse of the last address, so no stale match.
    task automatic idle(input int m);
        drv[m].valid = 1'b0;
        drv[m].addr = ~drv[m].addr;
    endtask : idle
endmodule : brd_master_model

`default_nettype wire

// [verification/tb_brd_decoder.sv]
// Self-checking testbench of the boot remap address decoder.
`default_nettype none

module tb_brd_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    import brd_pkg::*;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic bootSelectPin = 1'b1;
    logic [1:0] remapWrEn = 2'h0;
    logic [1:0] remapWrVal = 2'h0;
    brd_req_t [1:0] req;
    brd_dec_t [1:0] dec;
    logic remapBitInstrMaster;
    logic remapBitDataMaster;
    brd_boot_cfg_t bootCfg;
    int bad_count = 0;
    int checked = 0;
    // Slots inside the system window; the exact slots are arbitrary.
    localparam logic [31:0] ClkCtrlAddr = 32'hFFFF_FC00;
    localparam logic [31:0] MemCtrlAddr = 32'hFFFF_EC00;

    always #5 core_clk = ~core_clk;

    brd_master_model master (.core_clk(core_clk), .req(req));

    brd_decoder dut (
        .core_clk(core_clk),
        .rst(rst),
        .bootSelectPin(bootSelectPin),
        .remapWrEn(remapWrEn),
        .remapWrVal(remapWrVal),
        .req(req),
        .dec(dec),
        .remapBitInstrMaster(remapBitInstrMaster),
        .remapBitDataMaster(remapBitDataMaster),
        .bootCfg(bootCfg)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // The boot pin is set a full reset length ahead of release, so the capture is settled.
    task automatic do_reset(input logic pin);
        @(posedge core_clk);
        #1;
        rst = 1'b1;
        bootSelectPin = pin;
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'b0;
    endtask : do_reset

    // One request; the result stands in the cycle after the taking edge.
    task automatic probe(input int m, input logic [31:0] a, input brd_slave_t s,
                         input logic ab, input logic [2:0] cs);
        master.issue(m, a);
        @(posedge core_clk);
        #1;
        chk("valid", 32'h1, 32'(dec[m].valid));
        chk("slave", 32'(s), 32'(dec[m].slave));
        chk("abort", 32'(ab), 32'(dec[m].abort));
        if (s == SLV_EBI) begin
            chk("chipSel", 32'(cs), 32'(dec[m].chipSel));
        end
        master.idle(m);
    endtask : probe

    // One remap write, held over exactly one taking edge.
    task automatic remap_write(input logic [1:0] en, input logic [1:0] val);
        @(posedge core_clk);
        #1;
        remapWrEn = en;
        remapWrVal = val;
        @(posedge core_clk);
        #1;
        remapWrEn = 2'h0;
        remapWrVal = 2'h0;
    endtask : remap_write

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_rom_boot;
        chk("remapInstr", 32'h0, 32'(remapBitInstrMaster));
        chk("remapData", 32'h0, 32'(remapBitDataMaster));
        chk("bootCfg", 32'h8, 32'(bootCfg));
        probe(0, 32'h0000_0000, SLV_ROM, 1'b0, 3'h0);
        probe(1, 32'h0000_0000, SLV_ROM, 1'b0, 3'h0);
        probe(1, 32'h000F_FFFC, SLV_ROM, 1'b0, 3'h0);
        chk("bootOffset", 32'h000F_FFFC, 32'(dec[1].offset));
        @(posedge core_clk);
        #1;
        chk("idleValid", 32'h0, 32'(dec[1].valid));
    endtask : t_rom_boot

    task automatic t_fixed_map;
        probe(1, 32'h0040_0000, SLV_ROM, 1'b0, 3'h0);
        probe(0, 32'h0040_7FFC, SLV_ROM, 1'b0, 3'h0);
        probe(0, 32'h0040_8000, SLV_NONE, 1'b1, 3'h0);
        probe(1, 32'h0030_0000, SLV_SRAM, 1'b0, 3'h0);
        probe(0, 32'h0030_3FFC, SLV_SRAM, 1'b0, 3'h0);
        probe(0, 32'h0030_4000, SLV_NONE, 1'b1, 3'h0);
        probe(1, 32'h0050_0000, SLV_USB, 1'b0, 3'h0);
        probe(0, 32'h0060_0000, SLV_LCD, 1'b0, 3'h0);
        for (int i = 1; i <= 8; i++) begin
            probe(i % 2, {i[3:0], 28'h000_0010}, SLV_EBI, 1'b0, 3'(i - 1));
            chk("ebiOffset", 32'h0000_0010, 32'(dec[i % 2].offset));
        end
        for (int i = 9; i <= 14; i++) begin
            probe(i % 2, {i[3:0], 28'h000_0000}, SLV_NONE, 1'b1, 3'h0);
        end
        probe(1, 32'hFFFA_0000, SLV_APB, 1'b0, 3'h0);
        chk("sysPerUser", 32'h0, 32'(dec[1].sysPer));
        probe(0, 32'hFFFF_EB00, SLV_APB, 1'b0, 3'h0);
        chk("sysPer", 32'h1, 32'(dec[0].sysPer));
        chk("perSlot", 32'h0B, 32'(dec[0].perSlot));
    endtask : t_fixed_map

    // The data master is remapped first while the instruction master keeps the boot slave, then the instruction master is remapped too.
    task automatic t_remap;
        remap_write(2'h2, 2'h2);
        chk("remapData", 32'h1, 32'(remapBitDataMaster));
        chk("remapInstr", 32'h0, 32'(remapBitInstrMaster));
        probe(1, 32'h0000_0000, SLV_SRAM, 1'b0, 3'h0);
        probe(0, 32'h0000_0000, SLV_ROM, 1'b0, 3'h0);
        probe(1, 32'h0040_0000, SLV_ROM, 1'b0, 3'h0);
        bootSelectPin = 1'b0;
        probe(0, 32'h0000_0010, SLV_ROM, 1'b0, 3'h0);
        chk("romBoot", 32'h1, 32'(bootCfg.romBoot));
        // The data master's value bit and its strobe are both low here, so it must keep its 1.
        remap_write(2'h1, 2'h1);
        chk("remapInstrSet", 32'h1, 32'(remapBitInstrMaster));
        chk("remapDataKept", 32'h1, 32'(remapBitDataMaster));
        probe(0, 32'h0000_0000, SLV_SRAM, 1'b0, 3'h0);
    endtask : t_remap

    task automatic t_ext_boot;
        do_reset(1'b0);
        chk("remapData", 32'h0, 32'(remapBitDataMaster));
        chk("remapInstr", 32'h0, 32'(remapBitInstrMaster));
        chk("bootCfg", 32'h7, 32'(bootCfg));
        probe(0, 32'h0000_0000, SLV_EBI, 1'b0, 3'h0);
        probe(1, 32'h0008_0000, SLV_EBI, 1'b0, 3'h0);
        probe(1, 32'h0060_0000, SLV_LCD, 1'b0, 3'h0);
        // Boot software's speed-up order as data writes: oscillator, PLL, CS0 timings, clock.
        probe(1, ClkCtrlAddr, SLV_APB, 1'b0, 3'h0);
        probe(1, ClkCtrlAddr, SLV_APB, 1'b0, 3'h0);
        probe(1, MemCtrlAddr, SLV_APB, 1'b0, 3'h0);
        probe(1, ClkCtrlAddr, SLV_APB, 1'b0, 3'h0);
        chk("sysPerSeq", 32'h1, 32'(dec[1].sysPer));
        probe(0, 32'h0000_0004, SLV_EBI, 1'b0, 3'h0);
    endtask : t_ext_boot

    initial begin
        do_reset(1'b1);
        t_rom_boot();
        t_fixed_map();
        t_remap();
        t_ext_boot();
        conclude();
    end
endmodule : tb_brd_decoder

`default_nettype wire
